// [ptm_timer.sv]
/*
 Periodic timer unit: 10-bit counter, compare A and P, compare,
 timer/counter, PWM and single pulse modes, one output pin.
 Assumes the register port is on clk and the trigger pin is asynchronous.
*/
module ptm_timer (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire ptm_pkg::ptm_bus_t bus,
	output logic [7:0] rdata,
	// Pins
	input wire logic ext_clk_pin,
	output logic out_pin,
	output logic out_pin_oe,
	// Event flags
	output logic flag_a,
	output logic flag_p
);
	import ptm_pkg::*;

	logic [9:0] cnt_reg, cnt_next, cmpa_reg, cmpp_reg;
	logic run_reg, run_d_reg, fa_reg, fp_reg, pin_reg, pin_next;
	logic [7:0] ctrl1_reg;
	logic [7:0] rdata_reg;
	logic sy1_reg, sy2_reg, sy3_reg;

	function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
		hit = a == idx;
	endfunction

	wire logic wr_ctrl0 = bus.wr && hit(bus.addr, PTM_IDX_CTRL0);
	wire ptm_mode_t mode = ptm_mode_t'(ctrl1_reg[PTM_B_MODE +: 2]);
	wire ptm_act_t act = ptm_act_t'(ctrl1_reg[PTM_B_ACT +: 2]);
	wire logic oc = ctrl1_reg[PTM_B_OC];
	wire logic inv = ctrl1_reg[PTM_B_INV];
	wire logic cclr = ctrl1_reg[PTM_B_CCLR];
	wire logic pwm_fam = mode == PTM_MODE_PWM;
	wire logic single = pwm_fam && act == PTM_ACT_TOG;
	wire logic pwm = pwm_fam && !single;
	wire logic cmp_fam = mode == PTM_MODE_CMP || mode == PTM_MODE_TMR;
	wire logic rise = run_reg && !run_d_reg;
	wire logic trig = sy2_reg && !sy3_reg;
	// Matches only while counting; zero compare values never match
	wire logic ma = run_reg && cmpa_reg != PTM_ZERO10 && cnt_reg == cmpa_reg;
	wire logic mp = run_reg && cmpp_reg != PTM_ZERO10 && cnt_reg == cmpp_reg;
	wire logic ovf = run_reg && cnt_reg == PTM_CNT_MAX;
	// PWM period in counts, 1024 when compare P is zero
	wire logic [10:0] period = cmpp_reg == PTM_ZERO10 ? 11'h400
		: {1'b0, cmpp_reg};
	// Last count of a PWM period, so one period is exactly P counts
	wire logic pwm_end = run_reg && {1'b0, cnt_reg} == period - 11'h001;
	// Clear source per mode
	wire logic clr_cnt = (cmp_fam && cclr && ma)
		|| (cmp_fam && !cclr && mp)
		|| (pwm && pwm_end);
	wire logic set_a = (cmp_fam || pwm || single) && ma;
	wire logic set_p = (cmp_fam && !cclr && mp)
		|| (pwm && pwm_end);
	// Single pulse ends on A match
	wire logic sp_stop = single && ma;
	wire logic sw_run = bus.wdata[PTM_B_RUN];
	// Duty at or above period stays active
	wire logic duty_on = {1'b0, cnt_reg} < {1'b0, cmpa_reg}
		|| {1'b0, cmpa_reg} >= period;
	// PWM level: enabled waveform or forced level
	wire logic pwm_lvl = act == PTM_ACT_HIGH ? (duty_on ~^ oc)
		: act == PTM_ACT_LOW ? 1'b1 : 1'b0;

	// Counter advances while running, rising run restarts
	always_comb begin
		cnt_next = cnt_reg;
		if (rise)
			cnt_next = PTM_ZERO10;
		else if (run_reg)
			cnt_next = (clr_cnt || ovf) ? PTM_ZERO10 : cnt_reg + 10'h001;
	end

	// Pin state before polarity
	always_comb begin
		pin_next = pin_reg;
		if (rise && !pwm)
			pin_next = oc;
		else if (cmp_fam && set_a) begin
			case (act)
			PTM_ACT_LOW: pin_next = 1'b0;
			PTM_ACT_HIGH: pin_next = 1'b1;
			PTM_ACT_TOG: pin_next = !pin_reg;
			default: pin_next = pin_reg;
			endcase
		end else if (single && (sp_stop || !run_reg))
			pin_next = !oc;
		else if (pwm)
			pin_next = pwm_lvl;
	end

	always_ff @(posedge clk) begin
		sy1_reg <= ext_clk_pin;
		sy2_reg <= sy1_reg;
		sy3_reg <= sy2_reg;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= PTM_ZERO10;
			run_reg <= 1'b0;
			run_d_reg <= 1'b0;
			pin_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			run_d_reg <= run_reg;
			pin_reg <= pin_next;
			// Hardware stop wins over a software write
			if (sp_stop)
				run_reg <= 1'b0;
			else if (single && trig)
				run_reg <= 1'b1;
			else if (wr_ctrl0)
				run_reg <= sw_run;
		end
	end

	// Flags: a set in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (rst) begin
			fa_reg <= 1'b0;
			fp_reg <= 1'b0;
		end else begin
			fa_reg <= set_a || (fa_reg && !(wr_ctrl0 && bus.wdata[PTM_B_CLRA]));
			fp_reg <= set_p || (fp_reg && !(wr_ctrl0 && bus.wdata[PTM_B_CLRP]));
		end
	end

	// Compare pairs and control one
	always_ff @(posedge clk) begin
		if (rst) begin
			cmpa_reg <= PTM_ZERO10;
			cmpp_reg <= PTM_ZERO10;
			ctrl1_reg <= PTM_ZERO8;
		end else if (bus.wr) begin
			case (bus.addr)
			PTM_IDX_CMPA_LO: cmpa_reg[7:0] <= bus.wdata;
			PTM_IDX_CMPA_HI: cmpa_reg[9:8] <= bus.wdata[1:0];
			PTM_IDX_CMPP_LO: cmpp_reg[7:0] <= bus.wdata;
			PTM_IDX_CMPP_HI: cmpp_reg[9:8] <= bus.wdata[1:0];
			PTM_IDX_CTRL1: ctrl1_reg <= bus.wdata;
			default: ctrl1_reg <= ctrl1_reg;
			endcase
		end
	end

	// Read mux, upper high-byte bits zero
	logic [7:0] rd_mux;
	always_comb begin
		case (bus.addr)
		PTM_IDX_CNT_LO: rd_mux = cnt_reg[7:0];
		PTM_IDX_CNT_HI: rd_mux = {6'h00, cnt_reg[9:8]};
		PTM_IDX_CMPA_LO: rd_mux = cmpa_reg[7:0];
		PTM_IDX_CMPA_HI: rd_mux = {6'h00, cmpa_reg[9:8]};
		PTM_IDX_CMPP_LO: rd_mux = cmpp_reg[7:0];
		PTM_IDX_CMPP_HI: rd_mux = {6'h00, cmpp_reg[9:8]};
		PTM_IDX_CTRL0: rd_mux = {2'h0, fp_reg, fa_reg, 3'h0, run_reg};
		PTM_IDX_CTRL1: rd_mux = ctrl1_reg;
		default: rd_mux = PTM_ZERO8;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst)
			rdata_reg <= PTM_ZERO8;
		else if (bus.rd)
			rdata_reg <= rd_mux;
		else
			rdata_reg <= PTM_ZERO8;
	end

	assign rdata = rdata_reg;
	assign flag_a = fa_reg;
	assign flag_p = fp_reg;
	// Polarity, pin released in timer/counter and capture modes
	assign out_pin = pin_reg ^ inv;
	assign out_pin_oe = mode != PTM_MODE_TMR && mode != PTM_MODE_CAP;

	no_p_flag_a: assert property (@(posedge clk) disable iff (rst)
		cmp_fam && cclr |-> !set_p)
		else $error("P flag set with clear on A");
	zero_a_flag_a: assert property (@(posedge clk) disable iff (rst)
		cmpa_reg == PTM_ZERO10 |-> !set_a)
		else $error("A flag with zero compare A");
	run_count_a: assert property (@(posedge clk) disable iff (rst)
		run_reg && !rise && !clr_cnt && !ovf && !wr_ctrl0
		|=> cnt_reg == $past(cnt_reg) + 10'h001)
		else $error("Counter did not advance");
	hold_count_a: assert property (@(posedge clk) disable iff (rst)
		!run_reg && !rise |=> cnt_reg == $past(cnt_reg))
		else $error("Counter moved while stopped");
	sp_stop_a: assert property (@(posedge clk) disable iff (rst)
		sp_stop |=> !run_reg ##1 pin_reg == !oc)
		else $error("Single pulse did not end");
	init_pin_a: assert property (@(posedge clk) disable iff (rst)
		rise && !pwm |=> pin_reg == $past(oc))
		else $error("Pin not initialised on run");
	flag_a_set_a: assert property (@(posedge clk) disable iff (rst)
		set_a |=> fa_reg)
		else $error("A flag lost");
	high_zero_a: assert property (@(posedge clk) disable iff (rst)
		bus.rd && bus.addr == PTM_IDX_CNT_HI |=> rdata[7:2] == 6'h00)
		else $error("High byte upper bits set");
	ovf_wrap_a: assert property (@(posedge clk) disable iff (rst)
		ovf && !rise |=> cnt_reg == PTM_ZERO10)
		else $error("No wrap at maximum");

	sequence cnt_lo_rd_s;
		bus.rd && bus.addr == PTM_IDX_CNT_LO;
	endsequence

	sequence cnt_hi_rd_s;
		bus.rd && bus.addr == PTM_IDX_CNT_HI;
	endsequence

	sequence sp_start_s;
		single && rise;
	endsequence

	sequence sp_idle_s;
		single && !run_reg && !rise;
	endsequence

	cnt_lo_rd_a: assert property (@(posedge clk) disable iff (rst)
		cnt_lo_rd_s |=> rdata == $past(cnt_reg[7:0]))
		else $error("Counter low byte read wrong");

	cnt_hi_rd_a: assert property (@(posedge clk) disable iff (rst)
		cnt_hi_rd_s |=> rdata == {6'h00, $past(cnt_reg[9:8])})
		else $error("Counter high byte read wrong");

	rd_idle_a: assert property (@(posedge clk) disable iff (rst)
		!bus.rd |=> rdata == PTM_ZERO8)
		else $error("Read data outside read cycle");

	a_hi_zero_a: assert property (@(posedge clk) disable iff (rst)
		bus.rd && bus.addr == PTM_IDX_CMPA_HI |=> rdata[7:2] == 6'h00)
		else $error("Compare A high upper bits set");

	p_hi_zero_a: assert property (@(posedge clk) disable iff (rst)
		bus.rd && bus.addr == PTM_IDX_CMPP_HI |=> rdata[7:2] == 6'h00)
		else $error("Compare P high upper bits set");

	a_lo_wr_a: assert property (@(posedge clk) disable iff (rst)
		bus.wr && bus.addr == PTM_IDX_CMPA_LO
		|=> cmpa_reg[7:0] == $past(bus.wdata))
		else $error("Compare A low write lost");

	a_hi_wr_a: assert property (@(posedge clk) disable iff (rst)
		bus.wr && bus.addr == PTM_IDX_CMPA_HI
		|=> cmpa_reg[9:8] == $past(bus.wdata[1:0]))
		else $error("Compare A high write lost");

	p_lo_wr_a: assert property (@(posedge clk) disable iff (rst)
		bus.wr && bus.addr == PTM_IDX_CMPP_LO
		|=> cmpp_reg[7:0] == $past(bus.wdata))
		else $error("Compare P low write lost");

	p_hi_wr_a: assert property (@(posedge clk) disable iff (rst)
		bus.wr && bus.addr == PTM_IDX_CMPP_HI
		|=> cmpp_reg[9:8] == $past(bus.wdata[1:0]))
		else $error("Compare P high write lost");

	cmp_pclr_a: assert property (@(posedge clk) disable iff (rst)
		cmp_fam && !cclr && mp && !rise |=> cnt_reg == PTM_ZERO10)
		else $error("No clear on P match");

	cmp_aclr_a: assert property (@(posedge clk) disable iff (rst)
		cmp_fam && cclr && ma && !rise |=> cnt_reg == PTM_ZERO10)
		else $error("No clear on A match");

	p_flag_set_a: assert property (@(posedge clk) disable iff (rst)
		set_p |=> fp_reg)
		else $error("P flag lost");

	cmp_pin_hold_a: assert property (@(posedge clk) disable iff (rst)
		cmp_fam && !set_a && !rise |=> $stable(pin_reg))
		else $error("Pin moved without A flag");

	act_none_a: assert property (@(posedge clk) disable iff (rst)
		cmp_fam && act == PTM_ACT_NONE && !rise |=> $stable(pin_reg))
		else $error("Pin moved with no action");

	act_low_a: assert property (@(posedge clk) disable iff (rst)
		cmp_fam && set_a && act == PTM_ACT_LOW && !rise |=> !pin_reg)
		else $error("Pin not driven low");

	act_high_a: assert property (@(posedge clk) disable iff (rst)
		cmp_fam && set_a && act == PTM_ACT_HIGH && !rise |=> pin_reg)
		else $error("Pin not driven high");

	act_tog_a: assert property (@(posedge clk) disable iff (rst)
		cmp_fam && set_a && act == PTM_ACT_TOG && !rise
		|=> pin_reg != $past(pin_reg))
		else $error("Pin not toggled");

	tmr_release_a: assert property (@(posedge clk) disable iff (rst)
		mode == PTM_MODE_TMR |-> !out_pin_oe)
		else $error("Pin driven in timer mode");

	pwm_clear_a: assert property (@(posedge clk) disable iff (rst)
		pwm && pwm_end && !rise |=> cnt_reg == PTM_ZERO10)
		else $error("PWM period not cleared");

	pwm_full_a: assert property (@(posedge clk) disable iff (rst)
		pwm && act == PTM_ACT_HIGH && {1'b0, cmpa_reg} >= period
		|=> pin_reg == $past(oc))
		else $error("Full duty not held");

	pwm_p_flag_a: assert property (@(posedge clk) disable iff (rst)
		pwm && pwm_end |=> fp_reg)
		else $error("PWM P flag lost");

	force_high_a: assert property (@(posedge clk) disable iff (rst)
		pwm && act == PTM_ACT_LOW |=> pin_reg)
		else $error("Forced high not held");

	force_low_a: assert property (@(posedge clk) disable iff (rst)
		pwm && act == PTM_ACT_NONE |=> !pin_reg)
		else $error("Forced low not held");

	trig_run_a: assert property (@(posedge clk) disable iff (rst)
		single && trig && !sp_stop |=> run_reg)
		else $error("Trigger did not set run");

	sp_lead_a: assert property (@(posedge clk) disable iff (rst)
		sp_start_s |=> pin_reg == $past(oc))
		else $error("Pulse leading edge missing");

	sp_idle_a: assert property (@(posedge clk) disable iff (rst)
		sp_idle_s |=> pin_reg == !$past(oc))
		else $error("Pulse active while stopped");

	sp_count_a: assert property (@(posedge clk) disable iff (rst)
		single && run_reg && !rise
		|=> cnt_reg == $past(cnt_reg) + 10'h001)
		else $error("Single pulse counter cleared");

	rise_zero_a: assert property (@(posedge clk) disable iff (rst)
		rise |=> cnt_reg == PTM_ZERO10)
		else $error("Counter not restarted");
endmodule

// [ptm_pkg.sv]
/*
 Package for the periodic timer unit: register indexes, control fields,
 modes, pin actions and the bus carrier struct.
 Assumes an 8-bit register port with one-cycle strobes on a single clock.
*/
// How it works
// - Counter reads as low byte 7..0 and high byte bits 9..8.
// - Compare A is a 10-bit read/write pair, low byte and two bits.
// - Compare P is a 10-bit read/write pair, low byte and two bits.
// - Unused upper six bits of every high byte read as zero.
// - Mode field 00 selects compare match output mode.
// - Clear-select low: clear on P match or overflow if P zero; A and P flags.
// - Clear-select high: clear on A match, only A flag, never P flag.
// - Compare A zero: counter overflows at 3FF, no A flag.
// - Compare mode pin changes only on A flag or rising run bit; P match leaves it.
// - On A match pin-action sets, clears or toggles the pin; zero holds.
// - Rising run bit loads the pin with the output-control level, except in PWM.
// - Mode 11 counts and flags like compare mode, pin released.
// - PWM period is compare P, 1024 when zero; compare A is duty.
// - Duty at or above period keeps the output active all period.
// - PWM raises A flag on A match and P flag on the last count of each period.
// - PWM: output-control picks active level, pin-action enables or forces.
// - PWM keeps running while the pin is forced; clear-select ignored.
// - Single pulse: rising run starts count and pulse; pin edge sets run.
// - Single pulse ends on run clear or A match, which clears run.
// - Single pulse clears counter only on rising run or overflow at 3FF; P ignored.
// - Polarity bit inverts the pin, no effect in timer/counter mode.
package ptm_pkg;
	localparam int PTM_CW = 10;
	localparam logic [2:0] PTM_IDX_CNT_LO = 3'h0;
	localparam logic [2:0] PTM_IDX_CNT_HI = 3'h1;
	localparam logic [2:0] PTM_IDX_CMPA_LO = 3'h2;
	localparam logic [2:0] PTM_IDX_CMPA_HI = 3'h3;
	localparam logic [2:0] PTM_IDX_CMPP_LO = 3'h4;
	localparam logic [2:0] PTM_IDX_CMPP_HI = 3'h5;
	localparam logic [2:0] PTM_IDX_CTRL0 = 3'h6;
	localparam logic [2:0] PTM_IDX_CTRL1 = 3'h7;
	// Control zero: bit 0 run, bit 1 clears compare A flag, bit 2 P flag
	localparam int PTM_B_RUN = 0;
	localparam int PTM_B_CLRA = 1;
	localparam int PTM_B_CLRP = 2;
	localparam int PTM_B_FA = 4;
	localparam int PTM_B_FP = 5;
	// Control one: mode 7..6, pin action 5..4, oc 3, invert 2, clear 0
	localparam int PTM_B_MODE = 6;
	localparam int PTM_B_ACT = 4;
	localparam int PTM_B_OC = 3;
	localparam int PTM_B_INV = 2;
	localparam int PTM_B_CCLR = 0;
	localparam logic [9:0] PTM_CNT_MAX = 10'h3ff;
	localparam logic [9:0] PTM_ZERO10 = 10'h000;
	localparam logic [7:0] PTM_ZERO8 = 8'h00;

	typedef enum logic [1:0] {
		PTM_MODE_CMP = 2'b00,
		PTM_MODE_CAP = 2'b01,
		PTM_MODE_PWM = 2'b10,
		PTM_MODE_TMR = 2'b11
	} ptm_mode_t;

	typedef enum logic [1:0] {
		PTM_ACT_NONE = 2'b00,
		PTM_ACT_LOW = 2'b01,
		PTM_ACT_HIGH = 2'b10,
		PTM_ACT_TOG = 2'b11
	} ptm_act_t;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ptm_bus_t;
endpackage

// [ptm_pin_model.sv]
/*
 Far side of the timer: the trigger pin driver and the output pin wire.
 Assumes the same clock as the timer; trigger edges are made on demand.
*/
module ptm_pin_model (
	// Clock
	input wire logic clk,
	// Pin wires
	input wire logic out_pin,
	input wire logic out_pin_oe,
	output logic ext_clk_pin,
	output logic pin_level
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pull-up holds a released pin high, never the last driven level
	assign pin_level = out_pin_oe ? out_pin : 1'b1;
	initial ext_clk_pin = 1'b0;
	// Wide pulse, the unit synchronises the pin through two flops
	task automatic pulse();
		ext_clk_pin <= 1'b1;
		repeat (4) @(posedge clk);
		ext_clk_pin <= 1'b0;
	endtask
endmodule

// [periodic_timer_modes_tb.sv]
/*
 Testbench for the periodic timer: register tasks and mode scenarios.
 Assumes ptm_pkg is compiled first and a pin model drives the trigger.
*/
module periodic_timer_modes_tb;
	import ptm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	ptm_bus_t bus = '0;
	logic [7:0] rdata;
	logic ext_clk_pin, out_pin, out_pin_oe, flag_a, flag_p, pin_level;
	logic [7:0] d;
	int error_cnt = 0;
	int n_tests = 0;
	ptm_timer dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
		.ext_clk_pin(ext_clk_pin), .out_pin(out_pin),
		.out_pin_oe(out_pin_oe), .flag_a(flag_a), .flag_p(flag_p));
	ptm_pin_model pm (.clk(clk), .out_pin(out_pin),
		.out_pin_oe(out_pin_oe), .ext_clk_pin(ext_clk_pin),
		.pin_level(pin_level));
	initial forever #50 clk = ~clk;
	task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(logic [2:0] a, logic [7:0] v);
		bus <= '{a, v, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd(logic [2:0] a, output logic [7:0] v);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 v = rdata;
		@(posedge clk);
	endtask
	// Count pin-high cycles over two periods of four, phase free
	task automatic pwm(logic [7:0] c1, logic [7:0] a, logic [7:0] exp);
		int n;
		n = 0;
		wr(PTM_IDX_CTRL0, 8'h00);
		wr(PTM_IDX_CTRL1, c1);
		wr(PTM_IDX_CMPA_LO, a);
		wr(PTM_IDX_CTRL0, 8'h01);
		repeat (10) @(posedge clk);
		repeat (8) begin
			@(posedge clk);
			#1 n += (pin_level === 1'b1);
		end
		chk("pwm_high", 8'(n), exp);
	endtask
	// Waits off the edge so outputs launched by it have settled
	task automatic wt(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic conclude();
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#500000;
		error_cnt++;
		conclude();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		wr(PTM_IDX_CNT_LO, 8'h5a);
		rd(PTM_IDX_CNT_LO, d);
		chk("cnt_lo", d, 8'h00);
		wr(PTM_IDX_CMPA_HI, 8'hff);
		rd(PTM_IDX_CMPA_HI, d);
		chk("a_hi", d, 8'h03);
		wr(PTM_IDX_CMPP_HI, 8'hfe);
		rd(PTM_IDX_CMPP_HI, d);
		chk("p_hi", d, 8'h02);
		wr(PTM_IDX_CMPA_HI, 8'h00);
		wr(PTM_IDX_CMPP_HI, 8'h00);
		// Compare mode, initial high, pin driven low on A match
		wr(PTM_IDX_CMPA_LO, 8'h03);
		wr(PTM_IDX_CMPP_LO, 8'h06);
		wr(PTM_IDX_CTRL1, 8'h18);
		wr(PTM_IDX_CTRL0, 8'h01);
		wt(3);
		chk("pin_init", {7'h00, pin_level}, 8'h01);
		wt(12);
		chk("pin_match", {7'h00, pin_level}, 8'h00);
		chk("flags", {6'h00, flag_a, flag_p}, 8'h03);
		// Clear on A, P below A must stay silent
		wr(PTM_IDX_CTRL0, 8'h06);
		wr(PTM_IDX_CTRL1, 8'h19);
		wr(PTM_IDX_CMPP_LO, 8'h02);
		wr(PTM_IDX_CTRL0, 8'h01);
		wt(20);
		chk("flags_cclr", {6'h00, flag_a, flag_p}, 8'h02);
		// Timer/counter mode releases the pin, clear on A match
		wr(PTM_IDX_CTRL0, 8'h06);
		wr(PTM_IDX_CTRL1, 8'hd9);
		wr(PTM_IDX_CTRL0, 8'h01);
		wt(20);
		chk("tmr_oe", {7'h00, out_pin_oe}, 8'h00);
		chk("tmr_fa", {7'h00, flag_a}, 8'h01);
		// PWM: period 4, duty 1, full duty, invert, forced low
		wr(PTM_IDX_CMPP_LO, 8'h04);
		pwm(8'ha8, 8'h01, 8'h02);
		chk("pwm_fp", {7'h00, flag_p}, 8'h01);
		pwm(8'ha8, 8'h05, 8'h08);
		pwm(8'hac, 8'h01, 8'h06);
		pwm(8'h88, 8'h01, 8'h00);
		pwm(8'h8c, 8'h01, 8'h08);
		// Single pulse started by the trigger pin, ended by A match
		wr(PTM_IDX_CTRL0, 8'h06);
		wr(PTM_IDX_CMPA_LO, 8'h04);
		wr(PTM_IDX_CTRL1, 8'hb8);
		pm.pulse();
		wt(2);
		chk("sp_lead", {7'h00, pin_level}, 8'h01);
		wt(15);
		chk("sp_trail", {7'h00, pin_level}, 8'h00);
		chk("sp_fa", {7'h00, flag_a}, 8'h01);
		rd(PTM_IDX_CTRL0, d);
		chk("sp_run", {7'h00, d[PTM_B_RUN]}, 8'h00);
		// Compare A zero: overflow at maximum, no A flag, pin held
		wr(PTM_IDX_CTRL0, 8'h06);
		wr(PTM_IDX_CMPA_LO, 8'h00);
		wr(PTM_IDX_CMPP_LO, 8'h00);
		wr(PTM_IDX_CTRL1, 8'h18);
		wr(PTM_IDX_CTRL0, 8'h01);
		wt(1040);
		chk("zero_a_fa", {7'h00, flag_a}, 8'h00);
		chk("zero_a_pin", {7'h00, pin_level}, 8'h01);
		conclude();
	end
endmodule
